/* File: core/status_fifo_if.sv */
`timescale 1ns/10ps
interface status_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] head;
  logic       not_empty;
  logic       full;
  modport owner (output push, output push_data, output pop, input head, input not_empty, input full);
  modport store (input push, input push_data, input pop, output head, output not_empty, output full);
endinterface

/* File: core/usb_cfg_pkg.sv */
package usb_cfg_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] cfg_offset     = 4'h0;
  localparam logic [3:0] ctrl_offset    = 4'h4;
  localparam logic [3:0] status_offset  = 4'h8;
  localparam logic [3:0] line_offset    = 4'hc;

  // usb_config_reg field positions
  localparam int eye_bit     = 7;
  localparam int oemon_bit   = 6;
  localparam int pullup_bit  = 4;
  localparam int xdis_bit    = 3;
  localparam int fs_bit      = 2;
  localparam int pp_lsb      = 0;
  localparam logic [7:0] cfg_reset   = 8'h00;
  localparam logic [7:0] cfg_wmask   = 8'hdf;

  // usb_control_reg: module enable bit, and done flag position in the status word
  localparam int enable_bit  = 3;
  localparam int done_bit    = 8;

  // xfer_status byte layout
  localparam int ep_lsb      = 3;
  localparam int dir_bit     = 2;
  localparam int ppi_bit     = 1;

  localparam int fifo_depth  = 4;

  typedef enum logic [1:0] {
    pp_off     = 2'b00,
    pp_ep0_out = 2'b01,
    pp_all     = 2'b10,
    pp_ep1_15  = 2'b11
  } pp_mode_t;

  // transmit pair encodings {plus, minus}
  localparam logic [1:0] tx_se0  = 2'b00;
  localparam logic [1:0] tx_zero = 2'b01;
  localparam logic [1:0] tx_one  = 2'b10;

  // received pair encodings {plus, minus}
  typedef enum logic [1:0] {
    rx_se0   = 2'b00,
    rx_low   = 2'b01,
    rx_full  = 2'b10,
    rx_error = 2'b11
  } rx_state_t;

  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

endpackage

/* File: core/usb_sie_config_xcvr_status.sv */
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module usb_sie_config_xcvr_status (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial engine side
  input  wire logic        xfer_done,
  input  wire logic [3:0]  xfer_endpoint,
  input  wire logic        xfer_dir_in,
  input  wire logic        xfer_odd,
  input  wire logic        ep_request,
  output logic             ep_nak,
  input  wire logic        eng_tx_active,
  input  wire logic [1:0]  eng_tx_pair,
  output logic             rx_data,
  output logic [1:0]       rx_line_state,
  output logic             eng_enable,
  output logic             full_speed_sel,
  output logic [1:0]       pingpong_cfg,
  // external transceiver pins
  input  wire logic        line_plus_in,
  input  wire logic        line_minus_in,
  input  wire logic        diff_rx_in,
  output logic             drive_plus_out,
  output logic             drive_minus_out,
  output logic             ext_output_enable_n,
  // on-chip transceiver controls
  output logic             onchip_xcvr_en,
  output logic             onchip_tx_en,
  output logic [1:0]       onchip_tx_pair,
  output logic             pullup_dplus,
  output logic             pullup_dminus
);

  logic [7:0] usb_config_reg;
  logic       module_enable_bit;
  logic       eye_test_enable;
  logic       oe_monitor_enable;
  logic       pullup_enable;
  logic       xcvr_disable;
  logic       xfer_done_flag;

  // write channel capture
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        clear_done;
  logic        wr_cfg;
  logic        wr_ctrl;
  logic        wr_sts;
  logic        wr_bad;

  // read side
  logic [31:0] rd_word;
  logic        rd_bad;

  // pin synchronisers
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // transmit path
  logic       eye_phase;
  logic       tx_active;
  logic [1:0] tx_pair;
  logic       next_drive_plus;
  logic       next_drive_minus;

  status_fifo_if sq ();

  assign eye_test_enable   = usb_config_reg[usb_cfg_pkg::eye_bit];
  assign oe_monitor_enable = usb_config_reg[usb_cfg_pkg::oemon_bit];
  assign pullup_enable     = usb_config_reg[usb_cfg_pkg::pullup_bit];
  assign xcvr_disable      = usb_config_reg[usb_cfg_pkg::xdis_bit];
  assign full_speed_sel    = usb_config_reg[usb_cfg_pkg::fs_bit];
  assign pingpong_cfg      = usb_config_reg[usb_cfg_pkg::pp_lsb +: 2];
  assign eng_enable        = module_enable_bit;

  // ---------------- axi4-lite write ----------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= usb_cfg_pkg::resp_okay;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? usb_cfg_pkg::resp_slverr : usb_cfg_pkg::resp_okay;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // write address decode; the read-only line word and anything unmapped are refused
  always_comb begin
    wr_cfg  = 1'b0;
    wr_ctrl = 1'b0;
    wr_sts  = 1'b0;
    wr_bad  = 1'b0;
    case (aw_addr)
      usb_cfg_pkg::cfg_offset: begin
        wr_cfg = 1'b1;
      end
      usb_cfg_pkg::ctrl_offset: begin
        wr_ctrl = 1'b1;
      end
      usb_cfg_pkg::status_offset: begin
        wr_sts = 1'b1;
      end
      default: begin
        wr_bad = 1'b1;
      end
    endcase
  end

  // unimplemented bit 5 is masked off on every write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_config_reg <= usb_cfg_pkg::cfg_reset;
    end else if (wr_fire && wr_cfg && w_strb[0]) begin
      usb_config_reg <= w_data[7:0] & usb_cfg_pkg::cfg_wmask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_enable_bit <= 1'b0;
    end else if (wr_fire && wr_ctrl && w_strb[0]) begin
      module_enable_bit <= w_data[usb_cfg_pkg::enable_bit];
    end
  end

  // writing zero to the done bit pops the queue; ignored while the module is off
  assign clear_done = wr_fire && wr_sts && w_strb[1] && module_enable_bit
                      && !w_data[usb_cfg_pkg::done_bit] && xfer_done_flag;

  // ---------------- status fifo ----------------
  assign sq.push      = xfer_done && module_enable_bit;
  assign sq.push_data = {1'b0, xfer_endpoint, xfer_dir_in, xfer_odd, 1'b0};
  assign sq.pop       = clear_done;
  // the flag mirrors the queue head, so a refill re-raises it at once
  assign xfer_done_flag = sq.not_empty;
  assign ep_nak       = ep_request && module_enable_bit && sq.full;

  xfer_status_fifo #(
    .depth (usb_cfg_pkg::fifo_depth)
  ) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .q       (sq)
  );

  // ---------------- axi4-lite read ----------------
  assign s_axi_arready = !s_axi_rvalid;

  // status byte only meaningful while the flag is up
  always_comb begin
    rd_word = '0;
    rd_bad  = 1'b0;
    case (s_axi_araddr)
      usb_cfg_pkg::cfg_offset:    rd_word = {24'h000000, usb_config_reg};
      usb_cfg_pkg::ctrl_offset:   rd_word = {28'h0000000, module_enable_bit, 3'h0};
      usb_cfg_pkg::status_offset: rd_word = {23'h000000, xfer_done_flag, xfer_done_flag ? sq.head : 8'h00};
      usb_cfg_pkg::line_offset:   rd_word = {29'h00000000, pin_sync[0], rx_line_state};
      default:                    rd_bad  = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= usb_cfg_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_bad ? usb_cfg_pkg::resp_slverr : usb_cfg_pkg::resp_okay;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- receive path ----------------
  // {plus, minus, diff}; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {line_plus_in, line_minus_in, diff_rx_in};
      pin_sync <= pin_meta;
    end
  end

  // external pins only carry data when the transceiver is off-chip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data       <= 1'b0;
      rx_line_state <= usb_cfg_pkg::rx_se0;
    end else if (module_enable_bit && xcvr_disable) begin
      rx_data       <= pin_sync[0];
      rx_line_state <= pin_sync[2:1];
    end
  end

  // ---------------- transmit path ----------------
  // eye test: low speed starts J (diff one), full speed starts K (diff zero)
  // phase rests at zero while idle so every run opens on the right symbol
  always_ff @(posedge aclk) begin
    if (!aresetn || !eye_test_enable || !module_enable_bit) begin
      eye_phase <= 1'b0;
    end else begin
      eye_phase <= !eye_phase;
    end
  end

  assign tx_active = module_enable_bit && (eye_test_enable || eng_tx_active);

  always_comb begin
    if (eye_test_enable) begin
      tx_pair = (eye_phase ^ full_speed_sel) ? usb_cfg_pkg::tx_zero : usb_cfg_pkg::tx_one;
    end else if (eng_tx_pair == 2'b11) begin
      tx_pair = usb_cfg_pkg::tx_se0;
    end else begin
      tx_pair = eng_tx_pair;
    end
  end

  assign next_drive_plus  = tx_active && xcvr_disable && tx_pair[1];
  assign next_drive_minus = tx_active && xcvr_disable && tx_pair[0] && !next_drive_plus;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_plus_out  <= 1'b0;
      drive_minus_out <= 1'b0;
    end else begin
      drive_plus_out  <= next_drive_plus;
      drive_minus_out <= next_drive_minus;
    end
  end

  // pin works when monitoring or when off-chip; otherwise held high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_output_enable_n <= 1'b1;
    end else begin
      ext_output_enable_n <= !(tx_active && (oe_monitor_enable || xcvr_disable));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      onchip_tx_en   <= 1'b0;
      onchip_tx_pair <= usb_cfg_pkg::tx_se0;
    end else begin
      onchip_tx_en   <= tx_active && !xcvr_disable;
      onchip_tx_pair <= (tx_active && !xcvr_disable) ? tx_pair : usb_cfg_pkg::tx_se0;
    end
  end

  // ---------------- on-chip transceiver ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      onchip_xcvr_en <= 1'b0;
      pullup_dplus   <= 1'b0;
      pullup_dminus  <= 1'b0;
    end else begin
      onchip_xcvr_en <= module_enable_bit && !xcvr_disable;
      pullup_dplus   <= module_enable_bit && !xcvr_disable && pullup_enable && full_speed_sel;
      pullup_dminus  <= module_enable_bit && !xcvr_disable && pullup_enable && !full_speed_sel;
    end
  end

endmodule

/* File: core/xfer_status_fifo.sv */
`timescale 1ns/10ps
module xfer_status_fifo #(
  parameter int depth = usb_cfg_pkg::fifo_depth
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // queue port
  status_fifo_if.store    q
);
  localparam int aw = $clog2(depth);

  logic [7:0]  mem [depth];
  logic [aw-1:0] rd_ptr;
  logic [aw-1:0] wr_ptr;
  logic [aw:0]   count;
  logic          do_push;
  logic          do_pop;

  // a push into a full queue is dropped unless a pop frees a slot in the same cycle
  assign do_push     = q.push && (!q.full || do_pop);
  assign do_pop      = q.pop && (count != '0);
  assign q.full      = (count == (aw+1)'(depth));
  assign q.not_empty = (count != '0);
  assign q.head      = mem[rd_ptr];

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (aw+1)'(do_push) - (aw+1)'(do_pop);
    end
  end
endmodule

/* File: tb/usb_sie_checker.sv */
`timescale 1ns/10ps
module usb_sie_checker (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // register bus
  input wire logic [3:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  // engine
  input wire logic       ep_request,
  input wire logic       ep_nak,
  input wire logic       eng_enable,
  input wire logic       full_speed_sel,
  input wire logic [1:0] rx_line_state,
  // pins
  input wire logic       line_plus_in,
  input wire logic       line_minus_in,
  input wire logic       drive_plus_out,
  input wire logic       drive_minus_out,
  input wire logic       ext_output_enable_n,
  input wire logic       pullup_dplus,
  input wire logic       pullup_dminus,
  input wire logic       onchip_xcvr_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_not_illegal: assert property (!(drive_plus_out && drive_minus_out))
    else $error("both drive outputs high");
  a_nak_needs_req: assert property (ep_nak |-> ep_request && eng_enable)
    else $error("nak without request");
  a_dplus_full: assert property (pullup_dplus |-> full_speed_sel && !pullup_dminus)
    else $error("d plus pull-up at low speed");
  a_dminus_low: assert property (pullup_dminus |-> !full_speed_sel)
    else $error("d minus pull-up at full speed");
  a_idle_no_oe: assert property (!eng_enable ##1 !eng_enable |-> ext_output_enable_n)
    else $error("output enable while disabled");
  // two sync flops plus output register, two cycles of margin; only while the external pins are in use
  a_line_decode: assert property (
    (eng_enable && !onchip_xcvr_en && $stable({line_plus_in, line_minus_in}))[*5] |->
    rx_line_state == {line_plus_in, line_minus_in})
    else $error("line state not decoded");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_read_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 4'hc |=>
    s_axi_rvalid && s_axi_rresp == usb_cfg_pkg::resp_slverr)
    else $error("unmapped read not refused");
  c_nak: cover property (ep_nak);
  c_tx: cover property (!ext_output_enable_n);
  c_pullup: cover property (pullup_dplus || pullup_dminus);
endmodule

bind usb_sie_config_xcvr_status usb_sie_checker usb_sie_checker_inst (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .ep_request, .ep_nak, .eng_enable, .full_speed_sel, .rx_line_state, .line_plus_in, .line_minus_in,
  .drive_plus_out, .drive_minus_out, .ext_output_enable_n, .pullup_dplus, .pullup_dminus, .onchip_xcvr_en);

/* File: tb/usb_sie_config_xcvr_status_tb.sv */
`timescale 1ns/10ps
module usb_sie_config_xcvr_status_tb;
  localparam logic [3:0] a_cfg = usb_cfg_pkg::cfg_offset;
  localparam logic [3:0] a_ctl = usb_cfg_pkg::ctrl_offset;
  localparam logic [3:0] a_sts = usb_cfg_pkg::status_offset;
  localparam logic [1:0] ok = usb_cfg_pkg::resp_okay;
  localparam logic [1:0] err = usb_cfg_pkg::resp_slverr;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, xfer_done, xfer_dir_in, xfer_odd;
  logic ep_request, ep_nak, eng_tx_active, rx_data, eng_enable, full_speed_sel, line_plus_in, line_minus_in;
  logic diff_rx_in, drive_plus_out, drive_minus_out, ext_output_enable_n, onchip_xcvr_en, onchip_tx_en;
  logic pullup_dplus, pullup_dminus;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, xfer_endpoint;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, eng_tx_pair, rx_line_state, pingpong_cfg, onchip_tx_pair, host_pair, e;
  logic [7:0]  pc [4] = '{8'h14, 8'h10, 8'h18, 8'h04};
  logic [2:0]  pe [4] = '{3'h5, 3'h3, 3'h0, 3'h1};
  int          fails, cmp_count, i, n;

  usb_sie_config_xcvr_status usb_sie_config_xcvr_status_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .xfer_done, .xfer_endpoint, .xfer_dir_in, .xfer_odd, .ep_request, .ep_nak, .eng_tx_active,
    .eng_tx_pair, .rx_data, .rx_line_state, .eng_enable, .full_speed_sel, .pingpong_cfg, .line_plus_in,
    .line_minus_in, .diff_rx_in, .drive_plus_out, .drive_minus_out, .ext_output_enable_n, .onchip_xcvr_en,
    .onchip_tx_en, .onchip_tx_pair, .pullup_dplus, .pullup_dminus);
  usb_xcvr_model usb_xcvr_model_inst (.drive_plus_out, .drive_minus_out, .ext_output_enable_n, .host_pair,
    .line_plus_in, .line_minus_in, .diff_rx_in);

  always #4 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // handshakes are judged on the values that stood at the rising edge, then released after it
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    chk("bresp", r, er);
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk("rresp", r, er);
    if (er === ok) chk("rdata", rv, exp);
  endtask

  // speed, pull-up and transceiver settings only change while the module is off
  task automatic cfg_run(input logic [7:0] c);
    wr(a_ctl, 32'h0, 4'h1, ok);
    wr(a_cfg, {24'h0, c}, 4'h1, ok);
    wr(a_ctl, 32'h8, 4'h1, ok);
  endtask

  task automatic results();
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    {xfer_done, xfer_endpoint, xfer_dir_in, xfer_odd, ep_request, eng_tx_active, eng_tx_pair} = '0;
    host_pair = 2'h2;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rc(a_cfg, 32'h0, ok);
    wr(a_cfg, 32'hff, 4'h1, ok);
    rc(a_cfg, 32'hdf, ok);
    for (i = 0; i < 8; i++) begin
      wr(a_cfg, i, 4'h1, ok);
      chk("pp", pingpong_cfg, i[1:0]);
      chk("fs", full_speed_sel, i[2]);
    end
    wr(4'hc, 32'h0, 4'h1, err);
    rc(4'hd, 32'h0, err);
    wr(a_cfg, 32'h0c, 4'h1, ok);
    eng_tx_active <= 1'h1;
    xfer_done <= 1'h1;
    @(posedge aclk);
    xfer_done <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("oe idle", ext_output_enable_n, 1'h1);
    rc(a_sts, 32'h0, ok);
    for (i = 0; i < 4; i++) begin
      cfg_run(pc[i]);
      repeat (3) @(posedge aclk);
      chk("pullup", {pullup_dplus, pullup_dminus, onchip_xcvr_en}, pe[i]);
    end
    chk("oe mon off", ext_output_enable_n, 1'h1);
    cfg_run(8'h44);
    repeat (3) @(posedge aclk);
    chk("oe mon on", ext_output_enable_n, 1'h0);
    chk("onchip tx", {onchip_tx_en, onchip_tx_pair}, 3'h4);
    chk("enable", eng_enable, 1'h1);
    cfg_run(8'h0c);
    for (i = 0; i < 4; i++) begin
      eng_tx_pair <= i[1:0];
      repeat (3) @(posedge aclk);
      chk("tx pair", {drive_plus_out, drive_minus_out}, (i == 3) ? 2'h0 : i[1:0]);
      chk("oe ext", ext_output_enable_n, 1'h0);
    end
    eng_tx_active <= 1'h0;
    for (i = 0; i < 4; i++) begin
      host_pair <= i[1:0];
      repeat (6) @(posedge aclk);
      chk("oe listen", ext_output_enable_n, 1'h1);
      chk("rx line", rx_line_state, i[1:0]);
      chk("rx data", rx_data, i[1]);
    end
    for (i = 0; i < 2; i++) begin
      cfg_run(i ? 8'h8c : 8'h88);
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (ext_output_enable_n !== 1'h0 && n < 20);
      e = i ? 2'h1 : 2'h2;
      repeat (6) begin
        chk("eye", {drive_plus_out, drive_minus_out}, e);
        e = ~e;
        @(negedge aclk);
      end
    end
    cfg_run(8'h04);
    for (i = 0; i < 5; i++) begin
      @(posedge aclk);
      xfer_done <= 1'h1;
      xfer_endpoint <= 4'(i + 3);
      xfer_dir_in <= i[0];
      xfer_odd <= i[1];
    end
    @(posedge aclk);
    xfer_done <= 1'h0;
    ep_request <= 1'h1;
    @(negedge aclk);
    chk("nak full", ep_nak, 1'h1);
    for (i = 0; i < 4; i++) begin
      rc(a_sts, {23'h0, 1'h1, 1'h0, 4'(i + 3), i[0], i[1], 1'h0}, ok);
      wr(a_sts, 32'h0, 4'h2, ok);
      @(negedge aclk);
      chk("nak", ep_nak, 1'h0);
    end
    rc(a_sts, 32'h0, ok);
    ep_request <= 1'h0;
    results();
  end
endmodule

/* File: tb/usb_xcvr_model.sv */
`timescale 1ns/10ps
module usb_xcvr_model (
  // device drive side
  input  wire logic       drive_plus_out,
  input  wire logic       drive_minus_out,
  input  wire logic       ext_output_enable_n,
  // bus state from the host
  input  wire logic [1:0] host_pair,
  // toward the device
  output logic            line_plus_in,
  output logic            line_minus_in,
  output logic            diff_rx_in
);
  // while the device transmits, the transceiver hears its own drive
  assign {line_plus_in, line_minus_in} = ext_output_enable_n ? host_pair : {drive_plus_out, drive_minus_out};
  assign diff_rx_in = line_plus_in;
endmodule
